// ### bench/smbus_host_model.sv
// Host side of the byte port: pointer writes, data writes, reads.
// Assumes the bank clock; requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model import temp_regs_pkg::*; (
   // Clock and byte port.
   input wire logic clock,
   output logic wr_valid,
   output bus_write_type wr_byte,
   output logic rd_req,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   initial begin
      wr_valid = 1'b0;
      wr_byte = '0;
      rd_req = 1'b0;
   end
   // Pointer byte, then one data byte when more is set.
   task automatic send(input logic more, input logic [7:0] ptr, input logic [7:0] dat);
      @(posedge clock);
      wr_valid <= 1'b1;
      wr_byte <= '{first: 1'b1, data: ptr};
      if (more) begin
         @(posedge clock);
         wr_byte <= '{first: 1'b0, data: dat};
      end
      @(posedge clock);
      wr_valid <= 1'b0;
      wr_byte.data <= ~wr_byte.data;
   endtask
   // A missing answer leaves unknown data, which fails the compare.
   task automatic read(input logic set_ptr, input logic [7:0] ptr, output logic [7:0] dat);
      int n;
      if (set_ptr) send(1'b0, ptr, 8'h00);
      @(posedge clock);
      rd_req <= 1'b1;
      @(posedge clock);
      rd_req <= 1'b0;
      dat = 'x;
      for (n = 0; n < 4; n++) begin
         @(negedge clock);
         if (rd_valid === 1'b1) begin
            dat = rd_data;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// ### bench/temp_bank_checker_assertions.sv
// Port checker of the temperature register bank.
// Assumes binding to temp_sensor_register_bank.
`timescale 1ns/1ps
`default_nettype none
module temp_bank_checker import temp_regs_pkg::*; #(
   parameter int unsigned SLOW_PERIOD_CYCLES = 8192,
   parameter int unsigned FAST_PERIOD_CYCLES = 12
) (
   // Clock, reset and byte port.
   input wire logic clock,
   input wire logic rst,
   input wire logic wr_valid,
   input wire bus_write_type wr_byte,
   input wire logic rd_req,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Converter and pins.
   input wire logic conv_start,
   input wire chan_type conv_channel,
   input wire logic range_extended,
   input wire logic standby_select,
   input wire logic remote_alias_select,
   input wire logic trip_overtemp,
   input wire logic overtemp_output_n,
   input wire logic shared_pin_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_READ_ANSWER: assert property (rd_req |=> rd_valid) else $error("no answer");
   AST_READ_QUIET: assert property (!rd_req |=> !rd_valid) else $error("stray answer");
   AST_READ_HOLD: assert property (!rd_valid |-> $stable(rd_data)) else $error("data moved");
   AST_STANDBY_PINS: assert property ($past(standby_select) |-> overtemp_output_n && shared_pin_n)
      else $error("pin active in standby");
   AST_STANDBY_NO_START: assert property (standby_select [*3] |-> !conv_start)
      else $error("start in standby");
   AST_OVERTEMP_PIN: assert property (!$past(standby_select)
      |-> overtemp_output_n == !$past(trip_overtemp)) else $error("overtemp pin");
   AST_START_PULSE: assert property (conv_start |=> !conv_start) else $error("long start");
   AST_START_CHANNEL: assert property (conv_start |-> conv_channel != CHAN_ALL)
      else $error("bad channel");
   AST_CFG_BY_WRITE: assert property ($changed({standby_select, range_extended,
      remote_alias_select}) |-> $past(wr_valid) && !$past(wr_byte.first))
      else $error("config moved alone");
endmodule
bind temp_sensor_register_bank temp_bank_checker #(.SLOW_PERIOD_CYCLES(SLOW_PERIOD_CYCLES),
   .FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES)) chk_u (.clock, .rst, .wr_valid, .wr_byte, .rd_req,
   .rd_valid, .rd_data, .conv_start, .conv_channel, .range_extended, .standby_select,
   .remote_alias_select, .trip_overtemp, .overtemp_output_n, .shared_pin_n);
`default_nettype wire

// ### bench/temp_sensor_register_bank_bench.sv
// Self-checking bench of the temperature register bank.
// Assumes shortened periods; a small converter model answers starts.
`timescale 1ns/1ps
`default_nettype none
`include "temp_regs_defs.svh"
module temp_sensor_register_bank_bench import temp_regs_pkg::*;;
   logic clock, rst, wr_valid, rd_req, rd_valid, meas_valid, conv_start, avg_enable;
   logic range_extended, standby_select, remote_alias_select, overtemp_output_n, shared_pin_n;
   logic [7:0] rd_data;
   logic [4:0] trip;
   logic [2:0] pipe;
   bus_write_type wr_byte;
   meas_type meas;
   chan_type conv_channel;
   int errors = 0, checks = 0, cycles = 0, i, gap;
   logic [9:0] sample [4] = '{10'h000, 10'h154, 10'h2A7, 10'h1E9};
   logic [13:0] pins [8] = '{{8'h00, 6'b10000_0}, {8'h80, 6'b10010_1}, {8'h20, 6'b10000_1},
      {8'h20, 6'b00001_0}, {8'hA0, 6'b00001_0}, {8'h02, 6'b01010_1}, {8'h01, 6'b01000_0},
      {8'h01, 6'b00100_1}};
   smbus_host_model host_u (.clock, .wr_valid, .wr_byte, .rd_req, .rd_valid, .rd_data);
   temp_sensor_register_bank #(.SLOW_PERIOD_CYCLES(8192), .FAST_PERIOD_CYCLES(12)) dut_u (
      .clock, .rst, .wr_valid, .wr_byte, .rd_req, .rd_valid, .rd_data, .meas_valid, .meas,
      .conv_start, .conv_channel, .avg_enable, .range_extended, .standby_select,
      .remote_alias_select, .trip_local(trip[4]), .trip_first_remote(trip[3]),
      .trip_second_remote(trip[2]), .trip_overtemp(trip[1]), .trip_second_overtemp(trip[0]),
      .overtemp_output_n, .shared_pin_n);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Converter model: a tagged sample four cycles after each start.
   always @(posedge clock) begin
      pipe <= {pipe[1:0], conv_start};
      meas_valid <= pipe[2];
      meas <= '{channel: conv_channel, value: sample[conv_channel]};
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic set_ptr, input logic [7:0] ptr, input logic [7:0] exp);
      logic [7:0] got;
      host_u.read(set_ptr, ptr, got);
      check($sformatf("register %h", ptr), exp, got);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
      host_u.send(1'b1, ptr, dat);
   endtask
   // Reset for three cycles, then read before any pointer write.
   task automatic do_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(1'b0, 8'h00, `RESET_RESULT);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {rst, meas_valid, pipe, trip} = '0;
      meas = '0;
      do_reset();
      rd(1'b1, `ADDR_RATE_READ, `RESET_RATE);
      rd(1'b1, `ADDR_PRIMARY_CONFIG, `RESET_PRIMARY_CONFIG);
      repeat (400) @(posedge clock);
      wr(`ADDR_LOCAL_RESULT, 8'hFF);
      rd(1'b1, `ADDR_LOCAL_RESULT, sample[1][9:2]);
      rd(1'b1, `ADDR_REMOTE1_HIGH, sample[2][9:2]);
      rd(1'b1, `ADDR_REMOTE1_LOW, {sample[2][1:0], 6'h00});
      rd(1'b1, `ADDR_REMOTE2_HIGH, sample[3][9:2]);
      rd(1'b1, `ADDR_REMOTE2_LOW, {sample[3][1:0], 6'h00});
      wr(`ADDR_PRIMARY_CONFIG, 8'h08);
      rd(1'b1, `ADDR_REMOTE1_HIGH, sample[3][9:2]);
      rd(1'b1, `ADDR_REMOTE1_LOW, {sample[3][1:0], 6'h00});
      wr(`ADDR_PRIMARY_CONFIG, 8'hFF);
      trip <= 5'h1F;
      rd(1'b1, `ADDR_PRIMARY_CONFIG, 8'hEF);
      check("pins", 8'h03, {6'h00, overtemp_output_n, shared_pin_n});
      check("cfg", 8'h07, {5'h00, standby_select, range_extended, remote_alias_select});
      for (i = 0; i < 8; i++) begin
         wr(`ADDR_PRIMARY_CONFIG, pins[i][13:6]);
         trip <= pins[i][5:1];
         repeat (3) @(negedge clock);
         check("pins", {6'h00, ~pins[i][2], pins[i][0]}, {6'h00, overtemp_output_n,
            shared_pin_n});
      end
      wr(`ADDR_RATE_WRITE, 8'hFF);
      rd(1'b1, `ADDR_RATE_READ, 8'hBF);
      for (i = 1; i < 4; i++) begin
         wr(`ADDR_RATE_WRITE, {2'b00, i[1:0], 4'h8});
         repeat (3) do @(negedge clock); while (conv_start !== 1'b1);
         check("channel", {6'h00, i[1:0]}, {6'h00, conv_channel});
         // Code 8 divides the shortened slow period of 8192 by 256.
         gap = 0;
         do begin
            @(negedge clock);
            gap++;
         end while (conv_start !== 1'b1);
         check("period", 8'h20, gap[7:0]);
      end
      for (i = 0; i < 3; i++) begin
         wr(`ADDR_RATE_WRITE, i[0] ? 8'h87 : {2'b00, 2'b11, i[1], 3'h7 >> i[1]});
         @(negedge clock);
         check("averaging", {7'h00, i == 0}, {7'h00, avg_enable});
      end
      wr(`ADDR_LOCK_CONTROL, 8'hFF);
      rd(1'b1, `ADDR_LOCK_CONTROL, 8'h80);
      wr(`ADDR_PRIMARY_CONFIG, 8'h04);
      wr(`ADDR_LOCK_CONTROL, 8'h00);
      rd(1'b1, `ADDR_PRIMARY_CONFIG, 8'h01);
      rd(1'b1, `ADDR_LOCK_CONTROL, 8'h80);
      @(posedge clock);
      do_reset();
      rd(1'b1, `ADDR_LOCK_CONTROL, `RESET_LOCK_CONTROL);
      end_of_test();
   end
endmodule
`default_nettype wire

// ### rtl/conv_scheduler.sv
// Conversion period timer and channel sequencer.
// Assumes the converter answers each start with one meas_done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "temp_regs_defs.svh"

module conv_scheduler import temp_regs_pkg::*; #(
   parameter int unsigned SLOW_PERIOD_CYCLES = `CONV_PERIOD_SLOWEST_CYCLES,
   parameter int unsigned FAST_PERIOD_CYCLES = `CONV_PERIOD_FASTEST_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Control from the register bank.
   input wire logic standby,
   input wire rate_type rate,
   input wire logic avg_enable,
   // Converter handshake.
   input wire logic meas_done,
   output logic conv_start,
   output chan_type conv_channel
);

   typedef enum logic [1:0] {
      SCH_IDLE = 2'b00,
      SCH_ISSUE = 2'b01,
      SCH_WAIT = 2'b10
   } sch_state_type;

   // All state of the sequencer.
   typedef struct packed {
      sch_state_type state;
      logic [28:0] timer;
      chan_type chan;
      logic [4:0] samples;
   } sch_type;

   sch_type cur_r;
   sch_type cur_nxt;
   logic tick;
   logic continuous;
   logic [4:0] need;

   // Period in cycles for each rate code; code 0 is the slowest.
   // Continuous codes need no boundary; a one-cycle period keeps the
   // shift below from running to zero and wrapping the timer.
   function automatic logic [28:0] period_of(input logic [3:0] code);
      if (code >= `RATE_CODE_CONTINUOUS) begin
         period_of = 29'h0000001;
      end else if (code == `RATE_CODE_FASTEST) begin
         period_of = FAST_PERIOD_CYCLES[28:0];
      end else begin
         period_of = SLOW_PERIOD_CYCLES[28:0] >> code;
      end
   endfunction

   // Timer, boundary detection and channel walk.
   always_comb begin
      cur_nxt = cur_r;
      continuous = (rate.rate_code >= `RATE_CODE_CONTINUOUS);
      need = avg_enable ? `AVERAGE_SAMPLES : 5'h01;
      tick = (cur_r.timer == 29'h0000000);
      cur_nxt.timer = tick ? period_of(rate.rate_code) - 29'h0000001 : cur_r.timer - 29'h0000001;
      case (cur_r.state)
         SCH_IDLE: begin
            // A boundary, or back to back in continuous mode, opens a round.
            if (tick || continuous) begin
               cur_nxt.chan = (rate.chan_sel == CHAN_ALL) ? CHAN_LOCAL : rate.chan_sel;
               cur_nxt.samples = 5'h00;
               cur_nxt.state = SCH_ISSUE;
            end
         end
         SCH_ISSUE: begin
            cur_nxt.state = SCH_WAIT;
         end
         SCH_WAIT: begin
            if (meas_done) begin
               cur_nxt.samples = cur_r.samples + 5'h01;
               if (cur_r.samples + 5'h01 < need) begin
                  cur_nxt.state = SCH_ISSUE;
               end else if (rate.chan_sel == CHAN_ALL && cur_r.chan != CHAN_REMOTE2) begin
                  cur_nxt.chan = chan_type'(cur_r.chan + 2'b01);
                  cur_nxt.samples = 5'h00;
                  cur_nxt.state = SCH_ISSUE;
               end else begin
                  cur_nxt.state = SCH_IDLE;
               end
            end
         end
         default: begin
            cur_nxt.state = SCH_IDLE;
         end
      endcase
      // Standby drops any round and parks the timer.
      if (standby) begin
         cur_nxt.state = SCH_IDLE;
         cur_nxt.timer = 29'h0000000;
      end
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_r <= '{SCH_IDLE, 29'h0000000, CHAN_LOCAL, 5'h00};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign conv_start = (cur_r.state == SCH_ISSUE);
   assign conv_channel = cur_r.chan;

endmodule
`default_nettype wire

// ### rtl/result_averager.sv
// Per-channel averaging of converter samples into results.
// Assumes samples arrive one at a time, tagged with their channel.
`timescale 1ns/1ps
`default_nettype none
`include "temp_regs_defs.svh"

module result_averager import temp_regs_pkg::*; (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Samples in.
   input wire logic meas_valid,
   input wire meas_type meas,
   input wire logic avg_enable,
   // Results out.
   output logic res_valid,
   output meas_type res
);

   // All state: one accumulator and sample count per channel, plus the output result and its valid flag.
   typedef struct packed {
      logic [3:0][13:0] acc;
      logic [3:0][3:0] cnt;
      logic valid;
      meas_type res;
   } avg_type;

   avg_type cur_r;
   avg_type cur_nxt;
   logic [13:0] sum;

   // Accumulate sixteen samples, or pass each one through.
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.valid = 1'b0;
      sum = cur_r.acc[meas.channel] + {4'h0, meas.value};
      if (!avg_enable) begin
         // Restart partial sums so a later switch averages clean data.
         cur_nxt.acc = '0;
         cur_nxt.cnt = '0;
      end
      if (meas_valid) begin
         if (!avg_enable) begin
            cur_nxt.valid = 1'b1;
            cur_nxt.res = meas;
         end else if (cur_r.cnt[meas.channel] == 4'hF) begin
            cur_nxt.valid = 1'b1;
            cur_nxt.res = '{meas.channel, sum[13:4]};
            cur_nxt.acc[meas.channel] = 14'h0000;
            cur_nxt.cnt[meas.channel] = 4'h0;
         end else begin
            cur_nxt.acc[meas.channel] = sum;
            cur_nxt.cnt[meas.channel] = cur_r.cnt[meas.channel] + 4'h1;
         end
      end
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign res_valid = cur_r.valid;
   assign res = cur_r.res;

endmodule
`default_nettype wire

// ### rtl/temp_sensor_register_bank.sv
// Register bank of a three-channel temperature monitor.
// Holds the pointer, temperature results, configuration, lock and rate
// registers, schedules conversions and gates the alarm pin outputs.
// Assumes a serial slave engine on the same clock that hands over whole
// bytes, a converter that returns tagged samples, and external limit
// comparators that present their trip levels.
`timescale 1ns/1ps
`default_nettype none
`include "temp_regs_defs.svh"

module temp_sensor_register_bank import temp_regs_pkg::*; #(
   parameter int unsigned SLOW_PERIOD_CYCLES = `CONV_PERIOD_SLOWEST_CYCLES,
   parameter int unsigned FAST_PERIOD_CYCLES = `CONV_PERIOD_FASTEST_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Byte port from the serial slave engine.
   input wire logic wr_valid,
   input wire bus_write_type wr_byte,
   input wire logic rd_req,
   output logic rd_valid,
   output logic [7:0] rd_data,
   // Converter port.
   input wire logic meas_valid,
   input wire meas_type meas,
   output logic conv_start,
   output chan_type conv_channel,
   output logic avg_enable,
   output logic range_extended,
   output logic standby_select,
   output logic remote_alias_select,
   // Trip levels from the limit comparators.
   input wire logic trip_local,
   input wire logic trip_first_remote,
   input wire logic trip_second_remote,
   input wire logic trip_overtemp,
   input wire logic trip_second_overtemp,
   // Pin outputs, active low.
   output logic overtemp_output_n,
   output logic shared_pin_n
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------

   // Every register of the bank; bus registers are one byte wide, the read flag and pin levels one bit.
   typedef struct packed {
      logic [7:0] pointer;
      cfg1_type cfg1;
      rate_type rate;
      logic [7:0] lock_ctl;
      logic [7:0] local_result;
      logic [7:0] remote1_high;
      logic [7:0] remote1_low;
      logic [7:0] remote2_high;
      logic [7:0] remote2_low;
      logic rd_valid;
      logic [7:0] rd_data;
      logic overtemp_n;
      logic shared_n;
   } bank_type;

   bank_type cur_r; // Registered state.
   bank_type cur_nxt; // Next state, filled by the decode process.

   logic res_valid; // Averaged result ready this cycle.
   meas_type res; // The averaged result itself.
   logic locked; // Lockable registers are frozen.
   logic alarm_cause; // Any unblocked alarm source is tripped.

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------

   // True when the pointer selects the given offset.
   function automatic logic hit(input logic [7:0] ptr, input logic [7:0] addr);
      hit = (ptr == addr);
   endfunction

   // Read value of the register the pointer selects.
   // Offsets that hold nothing here read as zero.
   function automatic logic [7:0] read_value(input bank_type st);
      logic alias_on;
      alias_on = st.cfg1.remote_alias;
      read_value = 8'h00;
      if (hit(st.pointer, `ADDR_LOCAL_RESULT)) begin
         read_value = st.local_result;
      end else if (hit(st.pointer, `ADDR_REMOTE1_HIGH)) begin
         read_value = alias_on ? st.remote2_high : st.remote1_high;
      end else if (hit(st.pointer, `ADDR_REMOTE1_LOW)) begin
         read_value = alias_on ? st.remote2_low : st.remote1_low;
      end else if (hit(st.pointer, `ADDR_REMOTE2_HIGH)) begin
         read_value = st.remote2_high;
      end else if (hit(st.pointer, `ADDR_REMOTE2_LOW)) begin
         read_value = st.remote2_low;
      end else if (hit(st.pointer, `ADDR_RATE_READ)) begin
         read_value = st.rate & `RATE_RESERVED_MASK;
      end else if (hit(st.pointer, `ADDR_PRIMARY_CONFIG)) begin
         read_value = st.cfg1 & `CFG1_RESERVED_MASK;
      end else if (hit(st.pointer, `ADDR_LOCK_CONTROL)) begin
         read_value = st.lock_ctl;
      end
   endfunction

   // ------------------------------------------------------------
   // Conversion scheduling and averaging
   // ------------------------------------------------------------

   // Averaging applies only at the slow rates, and only while the
   // disable bit is clear; the three fast rates never average.
   assign avg_enable = !cur_r.rate.avg_disable && (cur_r.rate.rate_code < `RATE_CODE_FIRST_UNAVERAGED);

   // The sequencer owns the period timer and the channel walk.
   conv_scheduler #(
      .SLOW_PERIOD_CYCLES(SLOW_PERIOD_CYCLES),
      .FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES)
   ) u_sched (
      .clock(clock),
      .rst(rst),
      .standby(cur_r.cfg1.standby_select),
      .rate(cur_r.rate),
      .avg_enable(avg_enable),
      .meas_done(meas_valid),
      .conv_start(conv_start),
      .conv_channel(conv_channel)
   );

   // Samples are folded into results before they reach the registers.
   result_averager u_avg (
      .clock(clock),
      .rst(rst),
      .meas_valid(meas_valid),
      .meas(meas),
      .avg_enable(avg_enable),
      .res_valid(res_valid),
      .res(res)
   );

   // ------------------------------------------------------------
   // Alarm gating
   // ------------------------------------------------------------

   // Remote sources can be blocked one by one; local cannot.
   assign alarm_cause = trip_local
      || (trip_first_remote && !cur_r.cfg1.alarm_block_first_remote)
      || (trip_second_remote && !cur_r.cfg1.alarm_block_second_remote);

   assign locked = cur_r.lock_ctl[`LOCK_BIT_POS];

   // ------------------------------------------------------------
   // Next-state decode
   // ------------------------------------------------------------

   // Bus bytes, converter results and pin levels all resolve here.
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.rd_valid = 1'b0;

      // A read answers one cycle after the request with the selected
      // register; the pointer is left as it is.
      if (rd_req) begin
         cur_nxt.rd_valid = 1'b1;
         cur_nxt.rd_data = read_value(cur_r);
      end

      // Bus writes: the opening byte of a transaction is the pointer,
      // every later byte goes to the register the pointer selects.
      if (wr_valid) begin
         if (wr_byte.first) begin
            cur_nxt.pointer = wr_byte.data;
         end else if (!locked) begin
            // Result offsets are not decoded here, so bus writes to the
            // results fall through and change nothing.
            if (hit(cur_r.pointer, `ADDR_PRIMARY_CONFIG)) begin
               cur_nxt.cfg1 = wr_byte.data & `CFG1_RESERVED_MASK;
            end else if (hit(cur_r.pointer, `ADDR_RATE_WRITE)) begin
               cur_nxt.rate = wr_byte.data & `RATE_RESERVED_MASK;
            end else if (hit(cur_r.pointer, `ADDR_LOCK_CONTROL)) begin
               // Only the lock bit is stored; it can never be cleared
               // by the bus because a set lock blocks this write.
               cur_nxt.lock_ctl[`LOCK_BIT_POS] = wr_byte.data[`LOCK_BIT_POS];
            end
         end
         // While locked, writes to lockable registers are dropped
         // without any error indication.
      end

      // Converter results are the only source for the result registers.
      if (res_valid) begin
         case (res.channel)
            CHAN_LOCAL: begin
               cur_nxt.local_result = res.value[9:2];
            end
            CHAN_REMOTE1: begin
               cur_nxt.remote1_high = res.value[9:2];
               cur_nxt.remote1_low = {res.value[1:0], 6'b000000} & `LOW_BYTE_VALID_MASK;
            end
            CHAN_REMOTE2: begin
               cur_nxt.remote2_high = res.value[9:2];
               cur_nxt.remote2_low = {res.value[1:0], 6'b000000} & `LOW_BYTE_VALID_MASK;
            end
            default: begin
               cur_nxt.local_result = cur_r.local_result;
            end
         endcase
      end

      // Pin levels. Standby forces both pins to their inactive level,
      // since limits compared against stale results would mislead.
      if (cur_r.cfg1.standby_select) begin
         cur_nxt.overtemp_n = 1'b1;
         cur_nxt.shared_n = 1'b1;
      end else begin
         cur_nxt.overtemp_n = !trip_overtemp;
         if (cur_r.cfg1.pin_function_select) begin
            // Second overtemperature output; the alarm mask has no say.
            cur_nxt.shared_n = !trip_second_overtemp;
         end else begin
            cur_nxt.shared_n = !(alarm_cause && !cur_r.cfg1.alarm_mask);
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------

   // Power-on values: pointer and results zero, rate code 0x08.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_r.pointer <= `RESET_POINTER;
         cur_r.cfg1 <= `RESET_PRIMARY_CONFIG;
         cur_r.rate <= `RESET_RATE;
         cur_r.lock_ctl <= `RESET_LOCK_CONTROL;
         cur_r.local_result <= `RESET_RESULT;
         cur_r.remote1_high <= `RESET_RESULT;
         cur_r.remote1_low <= `RESET_RESULT;
         cur_r.remote2_high <= `RESET_RESULT;
         cur_r.remote2_low <= `RESET_RESULT;
         cur_r.rd_valid <= 1'b0;
         cur_r.rd_data <= 8'h00;
         cur_r.overtemp_n <= 1'b1;
         cur_r.shared_n <= 1'b1;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------

   // Read answer, straight from flip-flops.
   assign rd_valid = cur_r.rd_valid;
   assign rd_data = cur_r.rd_data;

   // Configuration levels for the converter and the limit logic.
   assign range_extended = cur_r.cfg1.range_extended;
   assign standby_select = cur_r.cfg1.standby_select;
   assign remote_alias_select = cur_r.cfg1.remote_alias;

   // Pin levels, registered.
   assign overtemp_output_n = cur_r.overtemp_n;
   assign shared_pin_n = cur_r.shared_n;

endmodule
`default_nettype wire

// ### shared/temp_regs_defs.svh
// Register offsets, field positions, reset values and timing counts
// of the temperature monitor register bank.
// Assumes a single 20 MHz core clock; included by bare name.
`ifndef TEMP_REGS_DEFS_SVH
`define TEMP_REGS_DEFS_SVH

// ----------------------------------------
// Register offsets (pointer values)
// ----------------------------------------
`define ADDR_LOCAL_RESULT 8'h00
`define ADDR_REMOTE1_HIGH 8'h01
`define ADDR_RATE_READ 8'h04
`define ADDR_RATE_WRITE 8'h0A
`define ADDR_REMOTE1_LOW 8'h10
`define ADDR_LOCK_CONTROL 8'h24
`define ADDR_REMOTE2_HIGH 8'h30
`define ADDR_REMOTE2_LOW 8'h33
`define ADDR_PRIMARY_CONFIG 8'h03

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define RESET_POINTER 8'h00
`define RESET_RESULT 8'h00
`define RESET_PRIMARY_CONFIG 8'h00
`define RESET_LOCK_CONTROL 8'h00
`define RESET_RATE 8'h08
`define CFG1_RESERVED_MASK 8'hEF
`define RATE_RESERVED_MASK 8'hBF
`define LOCK_BIT_POS 7
`define LOW_BYTE_VALID_MASK 8'hC0
`define RATE_CODE_FIRST_UNAVERAGED 4'h8
`define RATE_CODE_FASTEST 4'hA
`define RATE_CODE_CONTINUOUS 4'hB
`define AVERAGE_SAMPLES 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_FREQ_KHZ 20000
`define CONV_PERIOD_SLOWEST_MS 16000
`define CONV_PERIOD_SLOWEST_CYCLES (`CONV_PERIOD_SLOWEST_MS * `CLOCK_FREQ_KHZ)
`define CONV_PERIOD_FASTEST_US 15500
`define CONV_PERIOD_FASTEST_CYCLES (`CONV_PERIOD_FASTEST_US * `CLOCK_FREQ_KHZ / 1000)

`endif

// ### shared/temp_regs_pkg.sv
// Types shared by the temperature monitor register bank and its helpers.
// Assumes the companion defs header for all numeric constants.
package temp_regs_pkg;

   // Channel selector field and converter channel codes.
   typedef enum logic [1:0] {
      CHAN_ALL = 2'b00,
      CHAN_LOCAL = 2'b01,
      CHAN_REMOTE1 = 2'b10,
      CHAN_REMOTE2 = 2'b11
   } chan_type;

   // First configuration register layout.
   typedef struct packed {
      logic alarm_mask;
      logic standby_select;
      logic pin_function_select;
      logic reserved;
      logic remote_alias;
      logic range_extended;
      logic alarm_block_first_remote;
      logic alarm_block_second_remote;
   } cfg1_type;

   // Conversion rate and channel selector layout.
   typedef struct packed {
      logic avg_disable;
      logic reserved;
      chan_type chan_sel;
      logic [3:0] rate_code;
   } rate_type;

   // One converter measurement or one averaged result.
   typedef struct packed {
      chan_type channel;
      logic [9:0] value;
   } meas_type;

   // One byte written by the serial slave engine.
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } bus_write_type;

endpackage
